//--- design/bccr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Control A and B register bytes for one converter channel
interface bccr_cfg_if;
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   modport regs (output ctrl_a, output ctrl_b);
   modport chan (input ctrl_a, input ctrl_b);
endinterface
`default_nettype wire

//--- design/bccr_chan.sv
`timescale 1ns/1ps
`default_nettype none
module bccr_chan
   import bccr_pkg::*;
(
   bccr_cfg_if.chan cfg, // Channel settings
   input wire logic pin_a, // Synchronised first gate pin
   input wire logic pin_b, // Synchronised second gate pin
   output logic run, // Converter enabled
   output logic use_floor, // Regulate to floor setpoint
   output logic discharge, // Discharge resistor connected
   output logic fixed_pwm, // Forced PWM
   output logic [2:0] cur_limit, // Current limit code
   output logic [2:0] ramp_rate // Slew rate code
);
   logic gate_on;
   logic pin_lvl;
   logic lvl_mode;
   assign gate_on = cfg.ctrl_a[BCCR_A_GATE];
   assign pin_lvl = cfg.ctrl_a[BCCR_A_PINSEL] ? pin_b : pin_a;
   assign lvl_mode = gate_on & cfg.ctrl_a[BCCR_A_LVLMODE];
   // Pin only gates enable when not in roof/floor mode
   assign run = cfg.ctrl_a[BCCR_A_ON] & (~gate_on | lvl_mode | pin_lvl);
   assign use_floor = run & lvl_mode & ~pin_lvl;
   assign discharge = ~run & cfg.ctrl_a[BCCR_A_DISCH];
   assign fixed_pwm = cfg.ctrl_a[BCCR_A_FPWM];
   // Live field: no enable interlock, so new limits apply at once
   assign cur_limit = cfg.ctrl_b[BCCR_B_ILIM_LSB +: BCCR_FIELD_W];
   assign ramp_rate = cfg.ctrl_b[BCCR_B_RAMP_LSB +: BCCR_FIELD_W];
endmodule // bccr_chan
`default_nettype wire

//--- design/bccr_pkg.sv
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - Control A bit 7 turns the converter on when 1; resets to 1.
// - Control A bit 6 set: converter runs only if on bit and pin agree.
// - Control A bit 5 picks gate pin: 0 first pin, 1 second pin.
// - Control A bit 4 set: pin level picks roof or floor instead of enable.
// - Control A bit 3 connects discharge resistor while disabled; resets to 1.
// - Control A bit 1 forces fixed PWM when 1, auto PFM/PWM when 0.
// - Control B bits 5:3 give current limit, 0x2 is 2.5 A to 0x7 5.0 A.
// - Current limit may change while running; applied without disabling.
// - Control B bits 2:0 set ramp rate, 0x0 fastest to 0x7 slowest.
// - Converter one has its own pair at 0x04 and 0x05, same layout.
package bccr_pkg;
   localparam int BCCR_NCONV = 2;
   // Register indices; byte address is index times four
   localparam logic [7:0] BCCR_IDX_C0A = 8'h02;
   localparam logic [7:0] BCCR_IDX_C0B = 8'h03;
   localparam logic [7:0] BCCR_IDX_C1A = 8'h04;
   localparam logic [7:0] BCCR_IDX_C1B = 8'h05;
   localparam int BCCR_IDX_SHIFT = 2;
   // Control A fields
   localparam int BCCR_A_ON = 7;
   localparam int BCCR_A_GATE = 6;
   localparam int BCCR_A_PINSEL = 5;
   localparam int BCCR_A_LVLMODE = 4;
   localparam int BCCR_A_DISCH = 3;
   localparam int BCCR_A_FPWM = 1;
   // Control B fields
   localparam int BCCR_B_ILIM_LSB = 3;
   localparam int BCCR_B_RAMP_LSB = 0;
   localparam int BCCR_FIELD_W = 3;
   // Reset values, no writable masks (reserved bits stay as written)
   localparam logic [7:0] BCCR_RST_A = 8'hc8;
   localparam logic [7:0] BCCR_RST_B0 = 8'h12;
   localparam logic [7:0] BCCR_RST_B1 = 8'h32;
   localparam logic [2:0] BCCR_ILIM_MIN = 3'h2;
endpackage

//--- design/bccr_top.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bccr_top
   import bccr_pkg::*;
(
   input wire logic core_clk, // 100 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic external_gate_pin_a, // First enable pin, async
   input wire logic external_gate_pin_b, // Second enable pin, async
   output logic [1:0] conv_run, // Converter enabled per channel
   output logic [1:0] conv_use_floor, // Floor setpoint selected
   output logic [1:0] conv_discharge, // Discharge resistor on
   output logic [1:0] conv_fixed_pwm, // Forced PWM
   output logic [5:0] conv_current_limit, // Limit codes, channel 1 high
   output logic [5:0] conv_ramp_rate // Slew codes, channel 1 high
);
   import bccr_pkg::*;
   //------------------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------------------
   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_q;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end else begin
         pin_meta_q <= {external_gate_pin_b, external_gate_pin_a};
         pin_sync_q <= pin_meta_q;
      end
   end
   //------------------------------------------------------------
   // APB decode and registers
   //------------------------------------------------------------
   logic [7:0] c0a_q, c0b_q, c1a_q, c1b_q;
   logic [9:0] idx;
   logic hit_c0a, hit_c0b, hit_c1a, hit_c1b, mapped, aligned, wr_en;
   assign idx = paddr[11:BCCR_IDX_SHIFT];
   assign aligned = paddr[1:0] == 2'h0;
   assign hit_c0a = aligned & (idx == {2'h0, BCCR_IDX_C0A});
   assign hit_c0b = aligned & (idx == {2'h0, BCCR_IDX_C0B});
   assign hit_c1a = aligned & (idx == {2'h0, BCCR_IDX_C1A});
   assign hit_c1b = aligned & (idx == {2'h0, BCCR_IDX_C1B});
   assign mapped = hit_c0a | hit_c0b | hit_c1a | hit_c1b;
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = psel & penable & pwrite & mapped;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         c0a_q <= BCCR_RST_A;
         c0b_q <= BCCR_RST_B0;
         c1a_q <= BCCR_RST_A;
         c1b_q <= BCCR_RST_B1;
      end else if (wr_en) begin
         if (hit_c0a) c0a_q <= pwdata[7:0];
         if (hit_c0b) c0b_q <= pwdata[7:0];
         if (hit_c1a) c1a_q <= pwdata[7:0];
         if (hit_c1b) c1b_q <= pwdata[7:0];
      end
   end
   logic [7:0] rd_mux;
   assign rd_mux = hit_c0a ? c0a_q : hit_c0b ? c0b_q : hit_c1a ? c1a_q :
                   hit_c1b ? c1b_q : 8'h00;
   always_ff @(posedge core_clk) begin
      if (!rstn) prdata <= 32'h0;
      else if (psel & ~penable & ~pwrite) prdata <= {24'h0, rd_mux};
   end
   //------------------------------------------------------------
   // Channels
   //------------------------------------------------------------
   bccr_cfg_if cfg0 ();
   bccr_cfg_if cfg1 ();
   assign cfg0.ctrl_a = c0a_q;
   assign cfg0.ctrl_b = c0b_q;
   assign cfg1.ctrl_a = c1a_q;
   assign cfg1.ctrl_b = c1b_q;
   bccr_chan u_ch0 (.cfg(cfg0), .pin_a(pin_sync_q[0]), .pin_b(pin_sync_q[1]),
      .run(conv_run[0]), .use_floor(conv_use_floor[0]), .discharge(conv_discharge[0]),
      .fixed_pwm(conv_fixed_pwm[0]), .cur_limit(conv_current_limit[2:0]),
      .ramp_rate(conv_ramp_rate[2:0]));
   bccr_chan u_ch1 (.cfg(cfg1), .pin_a(pin_sync_q[0]), .pin_b(pin_sync_q[1]),
      .run(conv_run[1]), .use_floor(conv_use_floor[1]), .discharge(conv_discharge[1]),
      .fixed_pwm(conv_fixed_pwm[1]), .cur_limit(conv_current_limit[5:3]),
      .ramp_rate(conv_ramp_rate[5:3]));
   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   on_bit_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !c0a_q[BCCR_A_ON] |-> !conv_run[0]) else $error("ch0 runs with on bit clear");
   gate_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (c0a_q[BCCR_A_ON] && !c0a_q[BCCR_A_GATE]) |-> conv_run[0])
      else $error("ch0 not running ungated");
   pin_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (c0a_q[7:4] == 4'he && !pin_sync_q[1]) |-> !conv_run[0])
      else $error("ch0 ignores second pin");
   roof_floor_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (c1a_q[7:4] == 4'hd && !pin_sync_q[0]) |-> (conv_run[1] && conv_use_floor[1]))
      else $error("ch1 floor mode wrong");
   discharge_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_discharge[0] |-> (!conv_run[0] && c0a_q[BCCR_A_DISCH]))
      else $error("discharge while running");
   fpwm_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_fixed_pwm[1] == c1a_q[BCCR_A_FPWM]) else $error("pwm mode mismatch");
   ilim_live_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (wr_en && hit_c0b) |=> conv_current_limit[2:0] == $past(pwdata[5:3]))
      else $error("limit not applied");
   ramp_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (wr_en && hit_c1b) |=> conv_ramp_rate[5:3] == $past(pwdata[2:0]))
      else $error("ramp not applied");
endmodule // bccr_top
`default_nettype wire

//--- tb/bccr_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side enable pin drivers; levels move only just after a clock edge
module bccr_pin_drv (
   input wire logic core_clk, // Bench clock
   input wire logic [1:0] want, // Requested levels, bit 1 second pin
   output var logic pin_a = 1'b0, // First gate pin
   output var logic pin_b = 1'b0 // Second gate pin
);
   always @(posedge core_clk) begin
      pin_a <= want[0];
      pin_b <= want[1];
   end
endmodule // bccr_pin_drv
`default_nettype wire

//--- tb/test_buck_converter_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_buck_converter_control_regs;
   import bccr_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, pin_a, pin_b;
   logic [1:0] want = 2'h0, run, flr, dis, fpwm;
   logic [5:0] ilim, ramp;
   logic [11:0] adr [4] = '{12'h008, 12'h00c, 12'h010, 12'h014};
   logic [7:0] rst_v [4] = '{BCCR_RST_A, BCCR_RST_B0, BCCR_RST_A, BCCR_RST_B1};
   int fails = 0, compares = 0;
   always #5 core_clk = ~core_clk;
   bccr_top bccr_top_inst (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_gate_pin_a(pin_a), .external_gate_pin_b(pin_b),
      .conv_run(run), .conv_use_floor(flr), .conv_discharge(dis), .conv_fixed_pwm(fpwm),
      .conv_current_limit(ilim), .conv_ramp_rate(ramp));
   bccr_pin_drv bccr_pin_drv_inst (.core_clk(core_clk), .want(want), .pin_a(pin_a),
      .pin_b(pin_b));
   task automatic print_verdict;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Idle edge first, so psel is never set in the step that cleared it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pins pass the driver flop and a two-flop synchroniser
   task automatic go(input logic [1:0] w);
      @(posedge core_clk);
      want <= w;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, adr[i], 32'h0);
         chk(rd, {24'h0, rst_v[i]});
      end
      go(2'h0);
      chk(32'({run, dis}), 32'h3);
      chk(32'({ilim, ramp}), 32'hc92);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, adr[i], {24'hffffff, 8'ha5 ^ 8'(i)});
         apb(1'b0, adr[i], 32'h0);
         chk(rd, {24'h0, 8'ha5 ^ 8'(i)});
      end
      apb(1'b1, 12'h009, 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'ha5);
      apb(1'b1, 12'h008, 32'hc8);
      apb(1'b1, 12'h010, 32'he8);
      go(2'h1);
      chk(32'(run), 32'h1);
      go(2'h2);
      chk(32'({run, dis}), 32'h9);
      apb(1'b1, 12'h010, 32'hd8);
      go(2'h0);
      chk(32'({run, flr}), 32'ha);
      go(2'h1);
      chk(32'({run, flr}), 32'hc);
      apb(1'b1, 12'h008, 32'h82);
      apb(1'b1, 12'h010, 32'h48);
      go(2'h0);
      chk(32'({run, dis, fpwm}), 32'h19);
      apb(1'b1, 12'h00c, 32'h3f);
      apb(1'b1, 12'h014, 32'h15);
      go(2'h0);
      chk(32'({run[0], ilim, ramp}), 32'h15ef);
      print_verdict();
   end
endmodule // test_buck_converter_control_regs
`default_nettype wire
